// ===== src/rtcsp_pkg.sv
// constants and types of the two-wire slave port, its write buffer depth among them
package rtcsp_pkg;
    localparam logic [6:0] SLAVE_ADDR = 7'h68;   // 1101000
    localparam int         DATA_W     = 8;
    localparam int         PTR_W      = 6;       // 8 clock/control registers + 56 bytes of ram
    localparam int         FIFO_DEPTH = 16;
    localparam logic [3:0] BITS_BYTE  = 4'h8;
    localparam logic [3:0] CNT_ONE    = 4'h1;
    localparam logic [PTR_W-1:0] PTR_RESET = 6'h00;

    // gray codes along idle -> receive -> ack -> send -> master ack
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_RECV = 3'b001,
        ST_ACK  = 3'b011,
        ST_SEND = 3'b010,
        ST_MACK = 3'b110
    } rtcsp_state_t;

    typedef enum logic [1:0] {
        K_ADDR = 2'h0,
        K_PTR  = 2'h1,
        K_DATA = 2'h2,
        K_READ = 2'h3
    } rtcsp_kind_t;
endpackage

// ===== src/rtcsp_fifo_if.sv
// valid/ready carrier between the slave port and its write buffer
`timescale 1ns/10ps
interface rtcsp_fifo_if #(parameter int W = 14);
    logic         in_valid;
    logic         in_ready;
    logic [W-1:0] in_data;
    logic         out_valid;
    logic         out_ready;
    logic [W-1:0] out_data;

    modport fill  (output in_valid, output in_data, input in_ready);
    modport fifo  (input in_valid, input in_data, output in_ready,
                   output out_valid, output out_data, input out_ready);
    modport drain (input out_valid, input out_data, output out_ready);
endinterface

// ===== src/rtcsp_fifo.sv
// flip-flop fifo holding register writes until the register side takes them
`timescale 1ns/10ps
module rtcsp_fifo #(
    parameter int W     = 14,
    parameter int DEPTH = 16
) (
    input  wire logic   i_clock,
    input  wire logic   i_srst,
    rtcsp_fifo_if.fifo  f
);
    localparam int AW = $clog2(DEPTH);

    generate
        if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
            $error("rtcsp_fifo depth must be a power of two, at least 2");
        end
    endgenerate

    logic [W-1:0] mem_r [DEPTH];
    logic [AW:0]  wp_r;
    logic [AW:0]  wp_nxt;
    logic [AW:0]  rp_r;
    logic [AW:0]  rp_nxt;
    logic         push;
    logic         pop;

    assign f.out_valid = (wp_r != rp_r);
    assign f.in_ready  = (wp_r[AW-1:0] != rp_r[AW-1:0]) || (wp_r[AW] == rp_r[AW]);
    assign f.out_data  = mem_r[rp_r[AW-1:0]];
    assign push        = f.in_valid && f.in_ready;
    assign pop         = f.out_valid && f.out_ready;

    always_comb begin
        wp_nxt = push ? wp_r + 1'b1 : wp_r;
        rp_nxt = pop  ? rp_r + 1'b1 : rp_r;
    end

    always_ff @(posedge i_clock) begin
        if (i_srst) begin
            wp_r <= '0;
            rp_r <= '0;
        end else begin
            wp_r <= wp_nxt;
            rp_r <= rp_nxt;
        end
        // storage needs no reset; empty flags guard it
        if (push) begin
            mem_r[wp_r[AW-1:0]] <= f.in_data;
        end
    end
endmodule

// ===== src/rtcsp_slave.sv
// two-wire serial slave port of the real-time clock
//
// Function
// - start opens a transfer; stop or any nack closes it.
// - repeated start ends one, begins next.
// - every byte shifted msb first.
// - first byte: seven address bits, direction.
// - address 1101000 write: ack, write mode.
// - first write byte loads register pointer.
// - write bytes acked, stored at pointer; nack when buffer full.
// - address 1101000 read: ack, then transmit.
// - read starts at retained pointer value.
// - master nacks last byte; stop sending.
// - start copies time into read shadow.
`timescale 1ns/10ps
module rtcsp_slave #(
    parameter int PTR_W      = rtcsp_pkg::PTR_W,
    parameter int FIFO_DEPTH = rtcsp_pkg::FIFO_DEPTH
) (
    input  wire logic                   i_clock,
    input  wire logic                   i_srst,
    input  wire logic                   i_scl,
    input  wire logic                   i_sda,
    output logic                        o_sda_out,
    output logic                        o_sda_oe,
    output logic                        o_snapshot,
    output logic [PTR_W-1:0]            o_rd_addr,
    input  wire logic [7:0]             i_rd_data,
    output logic                        o_wr_valid,
    input  wire logic                   i_wr_ready,
    output logic [PTR_W-1:0]            o_wr_addr,
    output logic [7:0]                  o_wr_data,
    output logic                        o_busy
);
    localparam int WW = PTR_W + rtcsp_pkg::DATA_W;

    generate
        if (PTR_W < 3 || PTR_W > 8) begin : g_bad_ptr
            $error("rtcsp_slave pointer width must lie between 3 and 8");
        end
    endgenerate

    function automatic logic [PTR_W-1:0] ptr_inc(input logic [PTR_W-1:0] p);
        return p + 1'b1;   // wraps from the top register to zero
    endfunction

    rtcsp_fifo_if #(.W(WW)) wq ();

    rtcsp_fifo #(.W(WW), .DEPTH(FIFO_DEPTH)) u_fifo (
        .i_clock (i_clock),
        .i_srst  (i_srst),
        .f       (wq.fifo)
    );

    rtcsp_pkg::rtcsp_state_t state_r;
    rtcsp_pkg::rtcsp_state_t state_nxt;
    rtcsp_pkg::rtcsp_kind_t  kind_r;
    rtcsp_pkg::rtcsp_kind_t  kind_nxt;
    logic [7:0]       sh_r;
    logic [7:0]       sh_nxt;
    logic [3:0]       cnt_r;
    logic [3:0]       cnt_nxt;
    logic [PTR_W-1:0] ptr_r;
    logic [PTR_W-1:0] ptr_nxt;
    logic             nak_r;
    logic             nak_nxt;
    logic             snap_r;
    logic             snap_nxt;
    logic             scl_q;
    logic             sda_q;
    logic             push;
    logic             start_c;
    logic             stop_c;
    logic             rise;
    logic             fall;

    // sda moving while scl stays high marks a bus condition
    assign start_c = i_scl && scl_q && sda_q && !i_sda;
    assign stop_c  = i_scl && scl_q && !sda_q && i_sda;
    assign rise    = i_scl && !scl_q;
    assign fall    = !i_scl && scl_q;

    assign wq.in_valid  = push;
    assign wq.in_data   = {ptr_r, sh_r};
    assign wq.out_ready = i_wr_ready;
    assign o_wr_valid   = wq.out_valid;
    assign o_wr_addr    = wq.out_data[WW-1:8];
    assign o_wr_data    = wq.out_data[7:0];

    // open drain: only ever pulls low, scl is never driven
    assign o_sda_out  = 1'b0;
    assign o_sda_oe   = (state_r == rtcsp_pkg::ST_ACK) ||
                        ((state_r == rtcsp_pkg::ST_SEND) && !sh_r[7]);
    assign o_rd_addr  = ptr_r;
    assign o_snapshot = snap_r;
    assign o_busy     = (state_r != rtcsp_pkg::ST_IDLE);

    always_comb begin
        state_nxt = state_r;
        kind_nxt  = kind_r;
        sh_nxt    = sh_r;
        cnt_nxt   = cnt_r;
        ptr_nxt   = ptr_r;
        nak_nxt   = nak_r;
        snap_nxt  = 1'b0;
        push      = 1'b0;
        if (start_c) begin
            // a repeated start aborts whatever byte was under way
            state_nxt = rtcsp_pkg::ST_RECV;
            kind_nxt  = rtcsp_pkg::K_ADDR;
            cnt_nxt   = '0;
            snap_nxt  = 1'b1;
        end else if (stop_c) begin
            state_nxt = rtcsp_pkg::ST_IDLE;
        end else begin
            unique case (state_r)
                rtcsp_pkg::ST_IDLE: begin
                end
                rtcsp_pkg::ST_RECV: begin
                    if (rise) begin
                        sh_nxt  = {sh_r[6:0], i_sda};
                        cnt_nxt = cnt_r + 1'b1;
                    end else if (fall && cnt_r == rtcsp_pkg::BITS_BYTE) begin
                        cnt_nxt = '0;
                        unique case (kind_r)
                            rtcsp_pkg::K_ADDR: begin
                                if (sh_r[7:1] == rtcsp_pkg::SLAVE_ADDR) begin
                                    state_nxt = rtcsp_pkg::ST_ACK;
                                    kind_nxt  = sh_r[0] ? rtcsp_pkg::K_READ
                                                        : rtcsp_pkg::K_PTR;
                                end else begin
                                    state_nxt = rtcsp_pkg::ST_IDLE;
                                end
                            end
                            rtcsp_pkg::K_PTR: begin
                                ptr_nxt   = sh_r[PTR_W-1:0];
                                kind_nxt  = rtcsp_pkg::K_DATA;
                                state_nxt = rtcsp_pkg::ST_ACK;
                            end
                            default: begin
                                // a full buffer is answered with nack, as the
                                // port cannot hold the clock low to wait
                                if (wq.in_ready) begin
                                    push      = 1'b1;
                                    ptr_nxt   = ptr_inc(ptr_r);
                                    state_nxt = rtcsp_pkg::ST_ACK;
                                end else begin
                                    state_nxt = rtcsp_pkg::ST_IDLE;
                                end
                            end
                        endcase
                    end
                end
                rtcsp_pkg::ST_ACK: begin
                    if (rise) begin
                        cnt_nxt = rtcsp_pkg::CNT_ONE;
                    end else if (fall && cnt_r == rtcsp_pkg::CNT_ONE) begin
                        cnt_nxt = '0;
                        if (kind_r == rtcsp_pkg::K_READ) begin
                            sh_nxt    = i_rd_data;
                            state_nxt = rtcsp_pkg::ST_SEND;
                        end else begin
                            state_nxt = rtcsp_pkg::ST_RECV;
                        end
                    end
                end
                rtcsp_pkg::ST_SEND: begin
                    if (rise) begin
                        cnt_nxt = cnt_r + 1'b1;
                    end else if (fall) begin
                        if (cnt_r == rtcsp_pkg::BITS_BYTE) begin
                            cnt_nxt   = '0;
                            state_nxt = rtcsp_pkg::ST_MACK;
                        end else begin
                            sh_nxt = {sh_r[6:0], 1'b0};
                        end
                    end
                end
                rtcsp_pkg::ST_MACK: begin
                    if (rise) begin
                        nak_nxt = i_sda;
                        ptr_nxt = ptr_inc(ptr_r);
                        cnt_nxt = rtcsp_pkg::CNT_ONE;
                    end else if (fall && cnt_r == rtcsp_pkg::CNT_ONE) begin
                        cnt_nxt = '0;
                        if (nak_r) begin
                            state_nxt = rtcsp_pkg::ST_IDLE;
                        end else begin
                            sh_nxt    = i_rd_data;
                            state_nxt = rtcsp_pkg::ST_SEND;
                        end
                    end
                end
                default: begin
                    state_nxt = rtcsp_pkg::ST_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge i_clock) begin
        if (i_srst) begin
            state_r <= rtcsp_pkg::ST_IDLE;
            kind_r  <= rtcsp_pkg::K_ADDR;
            sh_r    <= 8'hff;
            cnt_r   <= 4'h0;
            ptr_r   <= rtcsp_pkg::PTR_RESET;
            nak_r   <= 1'b0;
            snap_r  <= 1'b0;
            scl_q   <= 1'b1;
            sda_q   <= 1'b1;
        end else begin
            state_r <= state_nxt;
            kind_r  <= kind_nxt;
            sh_r    <= sh_nxt;
            cnt_r   <= cnt_nxt;
            ptr_r   <= ptr_nxt;
            nak_r   <= nak_nxt;
            snap_r  <= snap_nxt;
            scl_q   <= i_scl;
            sda_q   <= i_sda;
        end
    end
endmodule

// ===== dv/rtcsp_slave_assertions.sv
// concurrent checks on the pins of the two-wire slave port
`timescale 1ns/10ps
module rtcsp_slave_assertions #(
    parameter int PTR_W = 6
) (
    input  wire logic             i_clock,
    input  wire logic             i_srst,
    input  wire logic             i_scl,
    input  wire logic             i_sda,
    input  wire logic             o_sda_oe,
    input  wire logic             o_snapshot,
    input  wire logic             o_busy,
    input  wire logic             o_wr_valid,
    input  wire logic             i_wr_ready,
    input  wire logic [PTR_W-1:0] o_wr_addr,
    input  wire logic [7:0]       o_wr_data
);
    logic scl_r;
    logic sda_r;
    logic start_c;
    logic stop_c;
    // history restarts at the idle bus level, as the port's does
    always_ff @(posedge i_clock) begin
        scl_r <= i_srst ? 1'b1 : i_scl;
        sda_r <= i_srst ? 1'b1 : i_sda;
    end
    assign start_c = i_scl & scl_r & sda_r & ~i_sda;
    assign stop_c  = i_scl & scl_r & ~sda_r & i_sda;
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (i_srst);
    property p_snap; start_c |=> o_snapshot; endproperty
    a_snap: assert property (p_snap) else $error("no snapshot after start");
    property p_snap_cause; o_snapshot |-> $past(start_c); endproperty
    a_snap_cause: assert property (p_snap_cause) else $error("snapshot without start");
    property p_snap_one; o_snapshot |=> !o_snapshot; endproperty
    a_snap_one: assert property (p_snap_one) else $error("snapshot longer than one");
    property p_stop_idle; stop_c |=> !o_busy; endproperty
    a_stop_idle: assert property (p_stop_idle) else $error("busy after stop");
    property p_busy_start; $rose(o_busy) |-> $past(start_c); endproperty
    a_busy_start: assert property (p_busy_start) else $error("busy without start");
    property p_quiet; !o_busy |-> !o_sda_oe; endproperty
    a_quiet: assert property (p_quiet) else $error("data pulled while idle");
    property p_hold_high; i_scl && scl_r |-> $stable(o_sda_oe); endproperty
    a_hold_high: assert property (p_hold_high) else $error("data moved in clock high");
    property p_rel_low; $fell(o_sda_oe) |-> !i_scl && !scl_r; endproperty
    a_rel_low: assert property (p_rel_low) else $error("ack released in clock high");
    property p_wr_hold;
        o_wr_valid && !i_wr_ready |=> o_wr_valid && $stable(o_wr_addr) && $stable(o_wr_data);
    endproperty
    a_wr_hold: assert property (p_wr_hold) else $error("write word not held");
    c_start: cover property (start_c);
    c_drain: cover property (o_wr_valid && i_wr_ready);
    c_ack: cover property ($rose(o_sda_oe) ##[1:400] $fell(o_sda_oe));
endmodule
bind rtcsp_slave rtcsp_slave_assertions #(.PTR_W(PTR_W)) i_rtcsp_slave_assertions (
    .i_clock(i_clock), .i_srst(i_srst), .i_scl(i_scl), .i_sda(i_sda),
    .o_sda_oe(o_sda_oe), .o_snapshot(o_snapshot), .o_busy(o_busy),
    .o_wr_valid(o_wr_valid), .i_wr_ready(i_wr_ready), .o_wr_addr(o_wr_addr),
    .o_wr_data(o_wr_data));

// ===== dv/rtcsp_master.sv
// two-wire bus master model on the far side of the slave port
`timescale 1ns/10ps
module rtcsp_master #(
    parameter int HALF = 100    // half of a 10 us serial clock period
) (
    input  wire logic i_clock,
    input  wire logic i_sda,
    output logic      o_scl,
    output logic      o_sda
);
    initial begin
        o_scl = 1'b1;
        o_sda = 1'b1;
    end
    task half;
        repeat (HALF) @(posedge i_clock);
        #1;
    endtask
    // also serves as repeated start: the bus is never released in between
    task start;
        o_sda = 1'b1;
        half;
        o_scl = 1'b1;
        half;
        o_sda = 1'b0;
        half;
        o_scl = 1'b0;
    endtask
    task stop;
        o_sda = 1'b0;
        half;
        o_scl = 1'b1;
        half;
        o_sda = 1'b1;
        half;
    endtask
    // nine clocks; released bits read back what the slave puts on the wire
    task xfer(input logic [7:0] d, input logic nine, output logic [7:0] q, output logic nack);
        logic [8:0] sh;
        logic [8:0] got;
        sh = {d, nine};
        for (int i = 8; i >= 0; i--) begin
            o_sda = sh[i];
            half;
            o_scl = 1'b1;
            half;
            got[i] = i_sda;
            o_scl = 1'b0;
        end
        q = got[8:1];
        nack = got[0];
    endtask
endmodule

// ===== dv/rtc_two_wire_slave_port_bench.sv
// self-checking bench for the two-wire slave port
`timescale 1ns/10ps
module rtc_two_wire_slave_port_bench;
    logic       clock = 1'b0;
    logic       srst = 1'b1;
    logic       wr_ready = 1'b0;
    logic       scl;
    logic       msda;
    logic       oe;
    logic       sda;
    logic       sda_drv;
    logic       snap;
    logic       busy;
    logic       wr_valid;
    logic [5:0] rd_addr;
    logic [5:0] wr_addr;
    logic [7:0] wr_data;
    logic [7:0] rd_data;
    logic [7:0] q;
    logic       nk;
    int         fails = 0;
    int         checks = 0;
    int         snaps = 0;
    always #25 clock = ~clock;
    always @(posedge clock) if (snap === 1'b1) snaps++;
    // open drain wire: the port only counts when enabled, and must pull low then
    assign sda = msda & (~oe | sda_drv);
    assign rd_data = {2'h0, rd_addr} ^ 8'h5c;
    rtcsp_slave i_rtcsp_slave (.i_clock(clock), .i_srst(srst), .i_scl(scl), .i_sda(sda),
        .o_sda_out(sda_drv), .o_sda_oe(oe), .o_snapshot(snap), .o_rd_addr(rd_addr),
        .i_rd_data(rd_data), .o_wr_valid(wr_valid), .i_wr_ready(wr_ready),
        .o_wr_addr(wr_addr), .o_wr_data(wr_data), .o_busy(busy));
    rtcsp_master i_rtcsp_master (.i_clock(clock), .i_sda(sda), .o_scl(scl), .o_sda(msda));
    function logic [7:0] exp_rd(input int a);
        return 8'(a % 64) ^ 8'h5c;
    endfunction
    task chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        checks++;
        if (got !== exp) begin
            fails++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask
    task send(input logic [7:0] d, input logic exp_nack);
        i_rtcsp_master.xfer(d, 1'b1, q, nk);
        chk("ack", {7'h0, exp_nack}, {7'h0, nk});
    endtask
    task t_write;
        i_rtcsp_master.start();
        send(8'hd0, 1'b0);
        send(8'h3e, 1'b0);
        for (int i = 0; i < 16; i++) send(8'(16 + i), 1'b0);
        send(8'hee, 1'b1);
        i_rtcsp_master.stop();
        // ready stays up so that each clock edge takes exactly one word
        wr_ready = 1'b1;
        for (int i = 0; i < 16; i++) begin
            chk("wr_valid", 8'h01, {7'h0, wr_valid});
            chk("wr_addr", 8'((62 + i) % 64), {2'h0, wr_addr});
            chk("wr_data", 8'(16 + i), wr_data);
            @(posedge clock);
            #1;
        end
        wr_ready = 1'b0;
        chk("wr_valid", 8'h00, {7'h0, wr_valid});
    endtask
    task t_badaddr;
        i_rtcsp_master.start();
        send(8'hd2, 1'b1);
        i_rtcsp_master.start();
        send(8'h50, 1'b1);
        i_rtcsp_master.stop();
        chk("busy", 8'h00, {7'h0, busy});
    endtask
    task t_read;
        int n0;
        n0 = snaps;
        i_rtcsp_master.start();
        send(8'hd0, 1'b0);
        send(8'h05, 1'b0);
        i_rtcsp_master.start();
        send(8'hd1, 1'b0);
        for (int i = 0; i < 3; i++) begin
            i_rtcsp_master.xfer(8'hff, (i == 2), q, nk);
            chk("rd_data", exp_rd(5 + i), q);
        end
        // the master's nack alone must end the transfer, before any stop
        repeat (2) @(posedge clock);
        #1;
        chk("busy_nack", 8'h00, {7'h0, busy});
        i_rtcsp_master.stop();
        chk("snaps", 8'(n0 + 2), 8'(snaps));
        chk("busy", 8'h00, {7'h0, busy});
    endtask
    task t_retained;
        i_rtcsp_master.start();
        send(8'hd1, 1'b0);
        i_rtcsp_master.xfer(8'hff, 1'b1, q, nk);
        chk("rd_data", exp_rd(8), q);
        i_rtcsp_master.stop();
    endtask
    task close_out;
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    initial begin
        repeat (6) @(posedge clock);
        #1 srst = 1'b0;
        t_write;
        t_badaddr;
        t_read;
        t_retained;
        close_out;
    end
    // the scenarios need about 55000 cycles
    initial begin
        repeat (90000) @(posedge clock);
        fails++;
        close_out;
    end
endmodule
